//--- logic/scst_defines.svh
// constants for the synchronous character serial transceiver
`ifndef SCST_DEFINES_SVH
`define SCST_DEFINES_SVH

`define SCST_OFF_STATUS 8'h00
`define SCST_OFF_RXDATA 8'h04
`define SCST_OFF_CTRL 8'h08
`define SCST_OFF_CONFIG 8'h0C

`define SCST_SW_RXRST_BIT 0
`define SCST_SW_CLR_BIT 1
`define SCST_SW_RST_VAL 2'h0

// reset control: 8 bits, parity omitted, odd sense
`define SCST_CTRL_RST_VAL 4'hE

`define SCST_LEN5 4'h5
`define SCST_LEN6 4'h6
`define SCST_LEN7 4'h7
`define SCST_LEN8 4'h8
`define SCST_FRAME_MAX 4'h9
`define SCST_CNT_ONE 4'h1
`define SCST_CNT_ZERO 4'h0

`define SCST_MASK5 8'h1F
`define SCST_MASK6 8'h3F
`define SCST_MASK7 8'h7F
`define SCST_MASK8 8'hFF

`endif

//--- logic/scst_pkg.sv
// types for the synchronous character serial transceiver
package scst_pkg;

   // latched format control
   typedef struct packed {
      logic len_hi;
      logic len_lo;
      logic omit;
      logic sense;
   } scst_ctrl_t;

   // all pins from outside the pclk domain, synchronised as one group
   typedef struct packed {
      logic tx_shift_clock;
      logic rx_shift_clock;
      logic rx_serial_in;
      logic tx_sync_load_strobe;
      logic tx_data_load_strobe;
      logic rx_sync_load_strobe;
      logic rx_reset;
      logic rx_avail_clear;
      logic rx_output_enable;
      logic control_latch_strobe;
      scst_ctrl_t ctrl;
      logic [7:0] input_bus;
   } scst_pin_t;

   // status word, bit 0 first from the right
   typedef struct packed {
      logic sync_char_sent;
      logic tx_buffer_empty;
      logic rx_searching;
      logic rx_parity_error;
      logic rx_overrun;
      logic sync_char_found;
      logic rx_char_available;
   } scst_status_t;

   typedef enum logic {
      SCST_RX_SEARCH = 1'b0,
      SCST_RX_CHAR = 1'b1
   } scst_rx_mode_t;

endpackage

//--- logic/scst_top.sv
// synchronous character serial transceiver with apb status port
//
// Overview of operation
// - tx_buffer_empty high while holding register free
// - next character: data if strobed, else sync
// - sync_char_sent marks sync character loaded
// - input bus loads three registers, separate strobes
// - rx_reset forces receive flags low
// - rx_reset release starts bit-by-bit sync search
// - match loads holding register, enters character mode
// - sync_char_found tracks each loaded character
// - parity mismatch raises rx_parity_error
// - transmit shifts on tx clock rising edge
// - receive samples on rx clock falling edge
// - rx_avail_clear forces rx_char_available low
// - rx_data_oe_n low while enabled, rx_data_out always driven
// - rx_char_available rises after complete character
// - uncleared previous character gives rx_overrun
// - data right-justified, unused upper lines low
// - two select inputs give 5 to 8 bits
// - parity_omit drops parity bit, clears parity error
// - next character loaded at last bit start
// - flags at frame end, available one edge later
`timescale 1ns/1ps
`include "scst_defines.svh"

module scst_top
   import scst_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parallel input side
   input wire logic [7:0] input_bus,
   input wire logic tx_sync_load_strobe,
   input wire logic tx_data_load_strobe,
   input wire logic rx_sync_load_strobe,
   input wire logic control_latch_strobe,
   input wire logic word_len_sel_hi,
   input wire logic word_len_sel_lo,
   input wire logic parity_omit,
   input wire logic parity_sense_sel,
   // receive control and status
   input wire logic rx_reset,
   input wire logic rx_avail_clear,
   input wire logic rx_output_enable,
   output logic rx_char_available,
   output logic rx_overrun,
   output logic rx_parity_error,
   output logic sync_char_found,
   output logic [7:0] rx_data_out,
   output logic rx_data_oe_n,
   // transmit status
   output logic tx_buffer_empty,
   output logic sync_char_sent,
   // serial line
   input wire logic tx_shift_clock,
   input wire logic rx_shift_clock,
   input wire logic rx_serial_in,
   output logic tx_serial_out
);

   // ****************************************************************
   // helper functions
   // ****************************************************************
   // select pair to length
   function automatic logic [3:0] char_bits(input scst_ctrl_t c);
      case ({c.len_hi, c.len_lo})
         2'b00: char_bits = `SCST_LEN5;
         2'b01: char_bits = `SCST_LEN6;
         2'b10: char_bits = `SCST_LEN7;
         default: char_bits = `SCST_LEN8;
      endcase
   endfunction

   function automatic logic [7:0] char_mask(input scst_ctrl_t c);
      case ({c.len_hi, c.len_lo})
         2'b00: char_mask = `SCST_MASK5;
         2'b01: char_mask = `SCST_MASK6;
         2'b10: char_mask = `SCST_MASK7;
         default: char_mask = `SCST_MASK8;
      endcase
   endfunction

   function automatic logic [3:0] frame_len(input scst_ctrl_t c);
      frame_len = char_bits(c) + {3'h0, ~c.omit};
   endfunction

   // sense high asks for even parity, data plus parity bit
   function automatic logic parity_bit(input logic [7:0] d,
                                       input logic sense);
      parity_bit = sense ? (^d) : ~(^d);
   endfunction

   function automatic logic [8:0] make_frame(input logic [7:0] d,
                                             input scst_ctrl_t c);
      logic [8:0] f;
      logic [7:0] m;
      m = d & char_mask(c);
      f = {1'b0, m};
      if (!c.omit) begin
         f[char_bits(c)] = parity_bit(m, c.sense);
      end
      make_frame = f;
   endfunction

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   scst_pin_t pin_raw;
   scst_pin_t pin_s1_q;
   scst_pin_t pin_s2_q;
   logic tclk_s3_q;
   logic rclk_s3_q;

   assign pin_raw = '{
      tx_shift_clock: tx_shift_clock,
      rx_shift_clock: rx_shift_clock,
      rx_serial_in: rx_serial_in,
      tx_sync_load_strobe: tx_sync_load_strobe,
      tx_data_load_strobe: tx_data_load_strobe,
      rx_sync_load_strobe: rx_sync_load_strobe,
      rx_reset: rx_reset,
      rx_avail_clear: rx_avail_clear,
      rx_output_enable: rx_output_enable,
      control_latch_strobe: control_latch_strobe,
      ctrl: '{len_hi: word_len_sel_hi, len_lo: word_len_sel_lo,
              omit: parity_omit, sense: parity_sense_sel},
      input_bus: input_bus};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         tclk_s3_q <= 1'b0;
         rclk_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         tclk_s3_q <= pin_s2_q.tx_shift_clock;
         rclk_s3_q <= pin_s2_q.rx_shift_clock;
      end
   end

   logic tx_rise;
   logic rx_fall;
   assign tx_rise = pin_s2_q.tx_shift_clock & ~tclk_s3_q;
   assign rx_fall = ~pin_s2_q.rx_shift_clock & rclk_s3_q;

   // ****************************************************************
   // apb registers
   // ****************************************************************
   logic [1:0] sw_ctrl_q;
   logic [31:0] prdata_q;
   logic rx_rst;
   logic avail_clr;
   logic addr_hit;
   scst_status_t status;
   scst_ctrl_t ctrl_q;
   scst_rx_mode_t rx_mode_q;
   logic [7:0] rx_hold_q;

   assign addr_hit = (paddr == `SCST_OFF_STATUS) ||
                     (paddr == `SCST_OFF_RXDATA) ||
                     (paddr == `SCST_OFF_CTRL) ||
                     (paddr == `SCST_OFF_CONFIG);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;
   assign prdata = prdata_q;

   // software levels add to the pins, they do not replace them
   assign rx_rst = pin_s2_q.rx_reset | sw_ctrl_q[`SCST_SW_RXRST_BIT];
   assign avail_clr = pin_s2_q.rx_avail_clear |
                      sw_ctrl_q[`SCST_SW_CLR_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_ctrl_q <= `SCST_SW_RST_VAL;
      end else if (psel && penable && pwrite &&
                   paddr == `SCST_OFF_CTRL) begin
         sw_ctrl_q <= pwdata[1:0];
      end
   end

   // read data captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `SCST_OFF_STATUS: prdata_q <= {25'h0, status};
            `SCST_OFF_RXDATA: prdata_q <= {24'h0, rx_hold_q};
            `SCST_OFF_CTRL: prdata_q <= {30'h0, sw_ctrl_q};
            `SCST_OFF_CONFIG: prdata_q <= {28'h0, ctrl_q};
            default: prdata_q <= 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // parallel loads
   // ****************************************************************
   logic [7:0] tx_sync_q;
   logic [7:0] tx_hold_q;
   logic [7:0] rx_sync_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SCST_CTRL_RST_VAL;
      end else if (pin_s2_q.control_latch_strobe) begin
         ctrl_q <= pin_s2_q.ctrl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sync_q <= 8'h00;
         tx_hold_q <= 8'h00;
         rx_sync_q <= 8'h00;
      end else begin
         if (pin_s2_q.tx_sync_load_strobe) begin
            tx_sync_q <= pin_s2_q.input_bus;
         end
         if (pin_s2_q.tx_data_load_strobe) begin
            tx_hold_q <= pin_s2_q.input_bus;
         end
         if (pin_s2_q.rx_sync_load_strobe) begin
            rx_sync_q <= pin_s2_q.input_bus;
         end
      end
   end

   // ****************************************************************
   // transmitter
   // ****************************************************************
   logic [8:0] tx_shift_q;
   logic [3:0] tx_cnt_q;
   logic tx_out_q;
   logic tds_seen_q;
   logic tx_empty_q;
   logic sct_q;
   logic tx_last;
   logic tx_load;

   assign tx_last = tx_cnt_q >= (frame_len(ctrl_q) - `SCST_CNT_ONE);
   // reload at the edge starting the last bit
   assign tx_load = tx_rise & tx_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift_q <= 9'h000;
         tx_cnt_q <= `SCST_CNT_ZERO;
         tx_out_q <= 1'b1;
      end else if (tx_rise) begin
         tx_out_q <= tx_shift_q[0];
         if (tx_last) begin
            tx_shift_q <= make_frame(tds_seen_q ? tx_hold_q : tx_sync_q,
                                     ctrl_q);
            tx_cnt_q <= `SCST_CNT_ZERO;
         end else begin
            tx_shift_q <= {1'b0, tx_shift_q[8:1]};
            tx_cnt_q <= tx_cnt_q + `SCST_CNT_ONE;
         end
      end
   end

   // a strobe in the load cycle counts for the next character
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tds_seen_q <= 1'b0;
      end else begin
         tds_seen_q <= pin_s2_q.tx_data_load_strobe |
                       (tds_seen_q & ~tx_load);
      end
   end

   // empty until strobed, again after reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_empty_q <= 1'b1;
      end else if (pin_s2_q.tx_data_load_strobe) begin
         tx_empty_q <= 1'b0;
      end else if (tx_load) begin
         tx_empty_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sct_q <= 1'b0;
      end else if (tx_load) begin
         sct_q <= ~tds_seen_q;
      end
   end

   assign tx_serial_out = tx_out_q;
   assign tx_buffer_empty = tx_empty_q;
   assign sync_char_sent = sct_q;

   // ****************************************************************
   // receiver
   // ****************************************************************
   logic [8:0] rx_shift_q;
   logic [3:0] rx_cnt_q;
   logic [8:0] rx_next;
   logic [8:0] rx_frame;
   logic [7:0] rx_data_w;
   logic rx_par_w;
   logic match_w;
   logic rx_load;
   logic rx_pend_q;
   logic rda_q;
   logic scf_q;
   logic ror_q;
   logic rpe_q;

   // new bit enters at the top; frame realigned to its own length
   assign rx_next = {pin_s2_q.rx_serial_in, rx_shift_q[8:1]};
   assign rx_frame = rx_next >> (`SCST_FRAME_MAX - frame_len(ctrl_q));
   assign rx_data_w = rx_frame[7:0] & char_mask(ctrl_q);
   assign rx_par_w = rx_frame[char_bits(ctrl_q)];
   assign match_w = rx_data_w == (rx_sync_q & char_mask(ctrl_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift_q <= 9'h000;
      end else if (rx_fall) begin
         rx_shift_q <= rx_next;
      end
   end

   // search after each bit, held while in reset
   always_comb begin
      case (rx_mode_q)
         SCST_RX_SEARCH: rx_load = rx_fall & ~rx_rst & match_w;
         SCST_RX_CHAR: rx_load = rx_fall & ~rx_rst &
            (rx_cnt_q >= (frame_len(ctrl_q) - `SCST_CNT_ONE));
         default: rx_load = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_mode_q <= SCST_RX_SEARCH;
         rx_cnt_q <= `SCST_CNT_ZERO;
      end else if (rx_rst) begin
         rx_mode_q <= SCST_RX_SEARCH;
         rx_cnt_q <= `SCST_CNT_ZERO;
      end else if (rx_load) begin
         rx_mode_q <= SCST_RX_CHAR;
         rx_cnt_q <= `SCST_CNT_ZERO;
      end else if (rx_fall && rx_mode_q == SCST_RX_CHAR) begin
         rx_cnt_q <= rx_cnt_q + `SCST_CNT_ONE;
      end
   end

   // data and flags settle at the frame's last edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hold_q <= 8'h00;
      end else if (rx_load) begin
         rx_hold_q <= rx_data_w;
      end
   end

   // receive flags forced low in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scf_q <= 1'b0;
         ror_q <= 1'b0;
         rpe_q <= 1'b0;
      end else if (rx_rst) begin
         scf_q <= 1'b0;
         ror_q <= 1'b0;
         rpe_q <= 1'b0;
      end else if (rx_load) begin
         scf_q <= match_w;
         ror_q <= rda_q & ~avail_clr;
         // parity check against the selected sense
         rpe_q <= ~ctrl_q.omit &
                  (rx_par_w != parity_bit(rx_data_w, ctrl_q.sense));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_pend_q <= 1'b0;
      end else if (rx_rst) begin
         rx_pend_q <= 1'b0;
      end else begin
         rx_pend_q <= rx_load | (rx_pend_q & ~rx_fall);
      end
   end

   // available one falling edge after the load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rda_q <= 1'b0;
      end else if (rx_rst || avail_clr) begin
         // clear level holds the flag low
         rda_q <= 1'b0;
      end else if (rx_pend_q && rx_fall) begin
         rda_q <= 1'b1;
      end
   end

   assign rx_char_available = rda_q;
   assign sync_char_found = scf_q;
   assign rx_overrun = ror_q;
   // omitted parity never reports an error
   assign rx_parity_error = rpe_q & ~ctrl_q.omit;
   assign rx_data_oe_n = ~pin_s2_q.rx_output_enable;
   assign rx_data_out = rx_hold_q;

   assign status = '{
      sync_char_sent: sct_q,
      tx_buffer_empty: tx_empty_q,
      rx_searching: rx_mode_q == SCST_RX_SEARCH,
      rx_parity_error: rx_parity_error,
      rx_overrun: ror_q,
      sync_char_found: scf_q,
      rx_char_available: rda_q};

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rx_reset_flags;
      rx_rst |=> !rda_q && !scf_q && !ror_q && !rpe_q;
   endproperty
   a_rx_reset_flags: assert property (p_rx_reset_flags)
      else $error("receive flags not cleared by rx_reset");

   property p_avail_clear;
      avail_clr |=> !rx_char_available;
   endproperty
   a_avail_clear: assert property (p_avail_clear)
      else $error("rx_char_available high after clear");

   property p_out_enable;
      rx_data_oe_n == !$past(pin_s1_q.rx_output_enable);
   endproperty
   a_out_enable: assert property (p_out_enable)
      else $error("output enable does not follow rx_output_enable");

   property p_tx_shift;
      tx_rise |=> tx_serial_out == $past(tx_shift_q[0]);
   endproperty
   a_tx_shift: assert property (p_tx_shift)
      else $error("tx bit not shifted on rising edge");

   property p_tx_source;
      tx_load |=> sync_char_sent == !$past(tds_seen_q);
   endproperty
   a_tx_source: assert property (p_tx_source)
      else $error("sync_char_sent wrong for reloaded character");

   property p_tx_empty;
      pin_s2_q.tx_data_load_strobe |=> !tx_buffer_empty;
   endproperty
   a_tx_empty: assert property (p_tx_empty)
      else $error("buffer empty while holding register full");

   property p_tx_reload;
      tx_load && !pin_s2_q.tx_data_load_strobe |=> tx_buffer_empty
         && tx_cnt_q == `SCST_CNT_ZERO;
   endproperty
   a_tx_reload: assert property (p_tx_reload)
      else $error("reload did not free the buffer");

   property p_overrun;
      rx_load && rda_q && !avail_clr |=> rx_overrun;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun missed");

   sequence s_loaded;
      rx_load && !rx_rst;
   endsequence
   // the next falling edge comes several pclk after the load, so the
   // pending marker carries the load up to it
   sequence s_next_fall;
      rx_pend_q && rx_fall && !rx_rst && !avail_clr;
   endsequence

   property p_search_match;
      s_next_fall |=> rx_char_available && rx_mode_q == SCST_RX_CHAR;
   endproperty
   a_search_match: assert property (p_search_match)
      else $error("character not available after next falling edge");

   property p_sync_found;
      s_loaded |=> sync_char_found == $past(match_w);
   endproperty
   a_sync_found: assert property (p_sync_found)
      else $error("sync_char_found not updated on load");

   property p_no_parity;
      ctrl_q.omit |-> !rx_parity_error;
   endproperty
   a_no_parity: assert property (p_no_parity)
      else $error("parity error with parity omitted");

endmodule

//--- tb/scst_line_model.sv
// line partner: link clock source and looped-back serial line
`timescale 1ns/1ps
module scst_line_model (
   // link side
   output logic tx_shift_clock,
   output logic rx_shift_clock,
   output logic rx_serial_in,
   input wire logic tx_serial_out,
   // fault injection
   input wire logic corrupt
);
   // ****************************************
   // shared link clock and looped-back line
   // ****************************************
   logic lclk;

   // offset start keeps the link out of phase with pclk
   initial begin
      lclk = 1'h0;
      #137;
      forever #400 lclk = ~lclk;
   end

   assign tx_shift_clock = lclk;
   assign rx_shift_clock = lclk;
   assign rx_serial_in = tx_serial_out ^ corrupt;
endmodule

//--- tb/test_sync_char_serial_transceiver.sv
// self-checking bench for the transceiver
`timescale 1ns/1ps
module test_sync_char_serial_transceiver;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, input_bus, rx_data_out, m;
   logic [31:0] pwdata, prdata, rd;
   logic tx_sync_load_strobe, tx_data_load_strobe, rx_sync_load_strobe;
   logic control_latch_strobe, word_len_sel_hi, word_len_sel_lo;
   logic parity_omit, parity_sense_sel, rx_reset, rx_avail_clear;
   logic rx_output_enable, rx_char_available, rx_overrun, rx_parity_error;
   logic sync_char_found, rx_data_oe_n, tx_buffer_empty, sync_char_sent;
   logic tx_shift_clock, rx_shift_clock, rx_serial_in, tx_serial_out;
   logic corrupt;
   int num_errors, tests_run;

   scst_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .input_bus, .tx_sync_load_strobe,
      .tx_data_load_strobe, .rx_sync_load_strobe, .control_latch_strobe,
      .word_len_sel_hi, .word_len_sel_lo, .parity_omit, .parity_sense_sel,
      .rx_reset, .rx_avail_clear, .rx_output_enable, .rx_char_available,
      .rx_overrun, .rx_parity_error, .sync_char_found, .rx_data_out,
      .rx_data_oe_n, .tx_buffer_empty, .sync_char_sent, .tx_shift_clock,
      .rx_shift_clock, .rx_serial_in, .tx_serial_out);

   scst_line_model u_line (.tx_shift_clock, .rx_shift_clock,
      .rx_serial_in, .tx_serial_out, .corrupt);

   // ****************************************
   // tasks
   // ****************************************
   task conclude;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task stall(input string msg);
      num_errors++;
      $display("MISMATCH %0t wait ran out: %s", $time, msg);
      conclude();
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) stall("apb");
   endtask

   // poll one status bit over the register bus until it reads v
   task wait_st(input int b, input logic v);
      int n;
      for (n = 0; n < 2000; n++) begin
         apb(1'h0, 8'h00, 32'h0);
         if (rd[b] === v) break;
      end
      if (n >= 2000) stall("status");
   endtask

   // strobes held 4 pclk, bus held past them for the synchroniser
   task pins(input logic [3:0] s, input logic [7:0] v);
      input_bus <= v;
      {tx_sync_load_strobe, tx_data_load_strobe, rx_sync_load_strobe,
         control_latch_strobe} <= s;
      repeat (4) @(posedge pclk);
      {tx_sync_load_strobe, tx_data_load_strobe, rx_sync_load_strobe,
         control_latch_strobe} <= 4'h0;
      repeat (3) @(posedge pclk);
   endtask

   task fmt(input logic [3:0] c);
      {word_len_sel_hi, word_len_sel_lo, parity_omit, parity_sense_sel} <= c;
      pins(4'h1, 8'h00);
   endtask

   // hold the receiver past a whole frame so that the search never
   // sees bits framed under the previous format
   task rxrst;
      apb(1'h1, 8'h08, 32'h1);
      repeat (80) @(posedge pclk);
      apb(1'h1, 8'h08, 32'h0);
   endtask

   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, input_bus} = '0;
      {tx_sync_load_strobe, tx_data_load_strobe, rx_sync_load_strobe} = '0;
      {control_latch_strobe, word_len_sel_hi, word_len_sel_lo} = '0;
      {parity_omit, parity_sense_sel, rx_avail_clear, corrupt} = '0;
      rx_reset = 1'h1;
      rx_output_enable = 1'h1;
      num_errors = 0;
      tests_run = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      check({3'h0, tx_buffer_empty, rx_char_available, rx_overrun,
         rx_parity_error, sync_char_found}, 8'h10);
      apb(1'h1, 8'h0C, 32'h0);
      apb(1'h0, 8'h0C, 32'h0);
      check(rd[7:0], 8'h0E);
      apb(1'h0, 8'h10, 32'h0);
      check({er, rd[6:0]}, 8'h80);
      rx_reset <= 1'h0;
      pins(4'hA, 8'h16);
      for (int i = 0; i < 4; i++) begin
         m = 8'hFF >> (3 - i);
         fmt({i[1:0], 2'h2});
         rxrst();
         wait_st(1, 1'h1);
         check(rx_data_out, 8'h16 & m);
         check({7'h0, rx_data_oe_n}, 8'h00);
         wait_st(6, 1'h1);
         check({7'h0, sync_char_sent}, 8'h01);
         pins(4'h4, 8'hE9);
         wait_st(6, 1'h0);
         wait_st(5, 1'h1);
         wait_st(1, 1'h0);
         check(rx_data_out, 8'hE9 & m);
      end
      wait_st(0, 1'h1);
      wait_st(2, 1'h1);
      rx_avail_clear <= 1'h1;
      repeat (4) @(posedge pclk);
      check({7'h0, rx_char_available}, 8'h00);
      rx_avail_clear <= 1'h0;
      wait_st(0, 1'h1);
      apb(1'h1, 8'h08, 32'h2);
      repeat (2) @(posedge pclk);
      check({7'h0, rx_char_available}, 8'h00);
      apb(1'h1, 8'h08, 32'h0);
      for (int s = 0; s < 2; s++) begin
         fmt({3'h6, s[0]});
         rxrst();
         wait_st(1, 1'h1);
         check({7'h0, rx_parity_error}, 8'h00);
         // inverting a whole frame flips the parity sense only
         corrupt <= 1'h1;
         wait_st(3, 1'h1);
         corrupt <= 1'h0;
      end
      fmt(4'hE);
      check({7'h0, rx_parity_error}, 8'h00);
      rx_reset <= 1'h1;
      repeat (4) @(posedge pclk);
      check({4'h0, rx_char_available, rx_overrun, rx_parity_error,
         sync_char_found}, 8'h00);
      rx_output_enable <= 1'h0;
      repeat (4) @(posedge pclk);
      check({7'h0, rx_data_oe_n}, 8'h01);
      conclude();
   end
endmodule
